// >>> rtl/ccer_pkg.sv
// Purpose: constants, codes and carrier types of the command channel error reporter
// Assumes: 50 MHz pclk, APB register access, 32-bit data
package ccer_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CMD_ID = 8'h00;
	localparam logic [7:0] OFF_COILS = 8'h04;
	localparam logic [7:0] OFF_ACK = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_ERR_CODE = 8'h10;
	localparam logic [7:0] OFF_CONFIG = 8'h14;
	localparam logic [7:0] OFF_REQ = 8'h18;
	localparam logic [7:0] OFF_GO = 8'h1C;
	localparam logic [7:0] OFF_VALUE = 8'h20;
	localparam logic [7:0] OFF_MIN = 8'h24;
	localparam logic [7:0] OFF_MAX = 8'h28;
	// bit positions
	localparam int CMD_COIL = 15;
	localparam int ERR_FLAG_BIT = 15;
	localparam int BUSY_BIT = 14;
	// trigger mode encodings
	localparam logic [7:0] TRIG_FIELDBUS = 8'h0A;
	localparam logic [7:0] TRIG_COMMAND = 8'h14;
	// failure codes
	localparam logic [31:0] CODE_SUCCESS = 32'd0;
	localparam logic [31:0] CODE_FB_TRIG = 32'd500;
	localparam logic [31:0] CODE_UNKNOWN_ID = 32'd510;
	localparam logic [31:0] CODE_ACT_FAIL = 32'd520;
	localparam logic [31:0] CODE_REASSERT = 32'd521;
	localparam logic [31:0] CODE_RELEASED = 32'd522;
	localparam logic [31:0] CODE_OTHER_PEND = 32'd523;
	localparam logic [31:0] CODE_MULTI = 32'd524;
	localparam logic [31:0] CODE_ACK_SUPP = 32'd525;
	localparam logic [31:0] CODE_EMPTY = 32'd10000;
	localparam logic [31:0] CODE_NOT_RECOG = 32'd10001;
	localparam logic [31:0] CODE_GRP_MISS = 32'd10100;
	localparam logic [31:0] CODE_GRP_UNK = 32'd10101;
	localparam logic [31:0] CODE_ITEM_MISS = 32'd10102;
	localparam logic [31:0] CODE_ITEM_UNK = 32'd10103;
	localparam logic [31:0] CODE_NOT_RD = 32'd10152;
	localparam logic [31:0] CODE_NOT_WR = 32'd10153;
	localparam logic [31:0] CODE_NOT_METH = 32'd10250;
	localparam logic [31:0] CODE_ARG_CNT = 32'd10251;
	localparam logic [31:0] CODE_BUSY = 32'd10252;
	localparam logic [31:0] CODE_BAD_ARG = 32'd10300;
	localparam logic [31:0] CODE_NO_DATA = 32'd10301;
	localparam logic [31:0] CODE_BELOW_MIN = 32'd10340;
	localparam logic [31:0] CODE_ABOVE_MAX = 32'd10341;
	localparam logic [31:0] CODE_EXTRA_ARGS = 32'd10350;
	localparam logic [31:0] CODE_NOT_READY = 32'd10900;
	localparam logic [31:0] CODE_STR_LONG = 32'd15100;
	localparam logic [31:0] CODE_CMP_OFF = 32'd20002;
	localparam logic [31:0] CODE_MASK_BAD = 32'd20003;
	localparam logic [31:0] CODE_CMD_TRIG = 32'd80100;
	localparam logic [31:0] CODE_TIMEOUT_CMD = 32'd80101;
	localparam logic [31:0] CODE_TIMEOUT_ACT = 32'd80150;
	localparam logic [31:0] CODE_PC_NOT_READY = 32'd80400;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int CMD_TIMEOUT_US = 1000000;
	localparam int CMD_TIMEOUT_CYC = (CMD_TIMEOUT_US / CLK_PERIOD_NS) * 1000;
	// reset values
	localparam logic [7:0] RST_TRIG = 8'h01;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {
		OP_GET = 2'h0,
		OP_SET = 2'h1,
		OP_METHOD = 2'h2
	} ccer_op_t;

	// request descriptor written by the frame parser, low bits of OFF_REQ
	typedef struct packed {
		logic frame_empty;
		logic cmd_known;
		logic group_present;
		logic group_known;
		logic item_present;
		logic item_known;
		ccer_op_t op;
		logic readable;
		logic writeable;
		logic is_method;
		logic arg_count_ok;
		logic data_present;
		logic extra_args;
		logic string_too_long;
		logic mask_valid;
		logic needs_fb_trig;
		logic needs_cmd_trig;
		logic needs_ready;
		logic product_change;
		logic uses_compare;
		logic has_limits;
	} ccer_req_t;

	// operating configuration, low bits of OFF_CONFIG
	typedef struct packed {
		logic compare_en;
		logic ready;
		logic [7:0] trig_mode;
	} ccer_cfg_t;
endpackage

// >>> rtl/ccer_code_sel.sv
// Purpose: pick the failure code of a request from its descriptor and configuration
// Assumes: purely combinational, first failing check wins
// Notes: a zero code means the request may run
`timescale 1ns/1ps
module ccer_code_sel (
	// request
	input ccer_pkg::ccer_req_t req,
	input ccer_pkg::ccer_cfg_t cfg,
	input wire logic via_coil,
	input wire logic signed [31:0] value,
	input wire logic signed [31:0] min_val,
	input wire logic signed [31:0] max_val,
	// verdict
	output logic [31:0] code
);
	import ccer_pkg::*;

	// identity and mode checks first, then the operation's own checks
	always_comb begin
		code = CODE_SUCCESS;
		if (req.frame_empty) begin
			code = CODE_EMPTY;
		end else if (!req.cmd_known) begin
			code = via_coil ? CODE_UNKNOWN_ID : CODE_NOT_RECOG;
		end else if (req.needs_cmd_trig && cfg.trig_mode != TRIG_COMMAND) begin
			code = CODE_CMD_TRIG;
		end else if (req.needs_fb_trig && cfg.trig_mode != TRIG_FIELDBUS) begin
			code = CODE_FB_TRIG;
		end else if (req.needs_ready && !cfg.ready) begin
			code = req.product_change ? CODE_PC_NOT_READY : CODE_NOT_READY;
		end else if (req.uses_compare && !cfg.compare_en) begin
			code = CODE_CMP_OFF;
		end else if (req.uses_compare && !req.mask_valid) begin
			code = CODE_MASK_BAD;
		end else if (req.op == OP_METHOD) begin
			if (!req.is_method)
				code = CODE_NOT_METH;
			else if (!req.arg_count_ok)
				code = CODE_ARG_CNT;
		end else if (!req.group_present) begin
			code = CODE_GRP_MISS;
		end else if (!req.group_known) begin
			code = CODE_GRP_UNK;
		end else if (!req.item_present) begin
			code = CODE_ITEM_MISS;
		end else if (!req.item_known) begin
			code = CODE_ITEM_UNK;
		end else if (req.op == OP_GET) begin
			if (!req.readable)
				code = CODE_NOT_RD;
			else if (req.extra_args)
				code = CODE_EXTRA_ARGS;
		end else if (req.op == OP_SET) begin
			if (!req.writeable)
				code = CODE_NOT_WR;
			else if (!req.data_present)
				code = CODE_NO_DATA;
			else if (req.string_too_long)
				code = CODE_STR_LONG;
			else if (req.has_limits && value < min_val)
				code = CODE_BELOW_MIN;
			else if (req.has_limits && value > max_val)
				code = CODE_ABOVE_MAX;
		end else begin
			code = CODE_BAD_ARG; // op code 3 names no operation
		end
	end
endmodule // ccer_code_sel

// >>> rtl/ccer_timeout.sv
// Purpose: time limit counter for a running execution
// Assumes: run stays high for the whole execution
// Notes: expire is a one-cycle pulse after LIMIT cycles of run
`timescale 1ns/1ps
module ccer_timeout #(
	parameter int unsigned LIMIT = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	output logic expire
);
	import ccer_pkg::*;

	logic [31:0] count;

	// count restarts whenever nothing runs, so each execution gets the full limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= RST_WORD;
			expire <= 1'b0;
		end else begin
			count <= (run && !expire) ? count + 32'd1 : RST_WORD;
			expire <= run && !expire && (count == LIMIT - 32'd1);
		end
	end
endmodule // ccer_timeout

// >>> rtl/ccer_top.sv
// Purpose: command channel coil handshake checker and error code reporter
// Assumes: coils and request descriptor arrive through APB writes
// Notes: the action itself runs outside; it answers with exec_done and exec_fail
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module ccer_top #(
	parameter int unsigned TIMEOUT_CYC = ccer_pkg::CMD_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// action engine
	output logic exec_start,
	output logic [3:0] exec_coil,
	output logic exec_frame,
	input wire logic exec_done,
	input wire logic exec_fail,
	// fieldbus mirror of status
	output logic [15:0] status_bits,
	output logic [15:0] ack_bits,
	output logic [31:0] error_code
);
	import ccer_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} ccer_state_t;

	ccer_state_t state;
	ccer_state_t next_state;
	logic [15:0] cmd_id;
	logic [15:0] coils;
	logic [15:0] coils_q;
	ccer_cfg_t cfg;
	ccer_req_t req;
	logic signed [31:0] value;
	logic signed [31:0] min_val;
	logic signed [31:0] max_val;
	logic [3:0] run_coil;
	logic run_frame;
	logic wr_take;
	logic go_wr;
	logic [15:0] rise;
	logic multi;
	logic [3:0] rise_idx;
	logic [31:0] sel_code;
	logic expire;
	logic rpt;
	logic [31:0] rpt_code;
	logic start;
	logic start_frame;
	logic [15:0] ack_set;
	logic [31:0] rd_word;
	logic rd_hit;

	// a write takes effect only in the access cycle that pready closes
	assign wr_take = psel && penable && pready && pwrite;
	assign go_wr = wr_take && (paddr == OFF_GO);
	assign rise = coils & ~coils_q;
	assign multi = (rise & (rise - 16'd1)) != 16'd0;

	// lowest raised coil; only used when exactly one rose
	always_comb begin
		rise_idx = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (rise[i])
				rise_idx = 4'(i);
		end
	end

	ccer_code_sel u_sel (
		.req(req),
		.cfg(cfg),
		.via_coil(|rise),
		.value(value),
		.min_val(min_val),
		.max_val(max_val),
		.code(sel_code)
	);

	ccer_timeout #(
		.LIMIT(TIMEOUT_CYC)
	) u_tmo (
		.pclk(pclk),
		.presetn(presetn),
		.run(state == ST_RUN),
		.expire(expire)
	);

	// one verdict per cycle; completion outranks handshake faults seen the same cycle
	always_comb begin
		next_state = state;
		rpt = 1'b0;
		rpt_code = CODE_SUCCESS;
		start = 1'b0;
		start_frame = 1'b0;
		ack_set = 16'h0000;
		unique case (state)
			ST_IDLE: begin
				if (multi) begin
					rpt = 1'b1;
					rpt_code = CODE_MULTI;
					ack_set = rise;
				end else if (|rise) begin
					if (rise_idx == 4'(CMD_COIL)) begin
						if (sel_code != CODE_SUCCESS) begin
							rpt = 1'b1;
							rpt_code = sel_code;
							ack_set = rise;
						end else begin
							start = 1'b1;
						end
					end else if (cfg.trig_mode != TRIG_FIELDBUS) begin
						rpt = 1'b1;
						rpt_code = CODE_FB_TRIG;
						ack_set = rise;
					end else begin
						start = 1'b1;
					end
				end else if (go_wr) begin
					if (sel_code != CODE_SUCCESS) begin
						rpt = 1'b1;
						rpt_code = sel_code;
					end else begin
						start = 1'b1;
						start_frame = 1'b1;
					end
				end
				if (start)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (expire) begin
					rpt = 1'b1;
					// abandoned: no acknowledge, the engine is told by the drop of busy
					if (run_frame || run_coil == 4'(CMD_COIL))
						rpt_code = CODE_TIMEOUT_CMD;
					else
						rpt_code = CODE_TIMEOUT_ACT;
					next_state = ST_IDLE;
				end else if (exec_done) begin
					rpt = 1'b1;
					next_state = ST_IDLE;
					if (!run_frame && !coils[run_coil]) begin
						rpt_code = CODE_ACK_SUPP;
					end else begin
						rpt_code = exec_fail ? CODE_ACT_FAIL : CODE_SUCCESS;
						if (!run_frame)
							ack_set[run_coil] = 1'b1;
					end
				end else if (|rise) begin
					rpt = 1'b1;
					if (!run_frame && rise[run_coil] && !multi)
						rpt_code = CODE_REASSERT;
					else
						rpt_code = CODE_OTHER_PEND;
				end else if (!run_frame && coils_q[run_coil] && !coils[run_coil]) begin
					rpt = 1'b1;
					rpt_code = CODE_RELEASED;
				end else if (go_wr) begin
					rpt = 1'b1;
					rpt_code = CODE_BUSY;
				end
			end
		endcase
	end

	// handshake state and the owner of the running execution
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			run_coil <= 4'h0;
			run_frame <= 1'b0;
			coils_q <= 16'h0000;
		end else begin
			state <= next_state;
			coils_q <= coils;
			if (start) begin
				run_coil <= rise_idx;
				run_frame <= start_frame;
			end
		end
	end

	// start pulse toward the action engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_start <= 1'b0;
			exec_coil <= 4'h0;
			exec_frame <= 1'b0;
		end else begin
			exec_start <= start;
			if (start) begin
				exec_coil <= rise_idx;
				exec_frame <= start_frame;
			end
		end
	end

	// error flag and code change only on a verdict; a success clears the flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_code <= CODE_SUCCESS;
			status_bits <= 16'h0000;
		end else begin
			if (rpt) begin
				error_code <= rpt_code;
				status_bits[ERR_FLAG_BIT] <= (rpt_code != CODE_SUCCESS);
			end
			status_bits[BUSY_BIT] <= (next_state == ST_RUN);
		end
	end

	// acknowledge per coil: held until the host drops the coil, set wins over clear
	for (genvar g = 0; g < 16; g++) begin : g_ack
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				ack_bits[g] <= 1'b0;
			else
				ack_bits[g] <= ack_set[g] | (ack_bits[g] & coils[g]);
		end
	end

	// software-written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_id <= 16'h0000;
			coils <= 16'h0000;
			cfg <= '{compare_en: 1'b0, ready: 1'b0, trig_mode: RST_TRIG};
			req <= '0;
			value <= RST_WORD;
			min_val <= RST_WORD;
			max_val <= RST_WORD;
		end else if (wr_take) begin
			case (paddr)
				OFF_CMD_ID: cmd_id <= pwdata[15:0];
				OFF_COILS: coils <= pwdata[15:0];
				OFF_CONFIG: cfg <= pwdata[$bits(ccer_cfg_t)-1:0];
				OFF_REQ: req <= pwdata[$bits(ccer_req_t)-1:0];
				OFF_VALUE: value <= pwdata;
				OFF_MIN: min_val <= pwdata;
				OFF_MAX: max_val <= pwdata;
				default: ;
			endcase
		end
	end

	// read decode; unmapped addresses read zero with an error answer
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr)
			OFF_CMD_ID: rd_word = {16'h0000, cmd_id};
			OFF_COILS: rd_word = {16'h0000, coils};
			OFF_ACK: rd_word = {16'h0000, ack_bits};
			OFF_STATUS: rd_word = {16'h0000, status_bits};
			OFF_ERR_CODE: rd_word = error_code;
			OFF_CONFIG: rd_word = {{(32 - $bits(ccer_cfg_t)){1'b0}}, cfg};
			OFF_REQ: rd_word = {{(32 - $bits(ccer_req_t)){1'b0}}, req};
			OFF_GO: rd_word = 32'h0000_0000;
			OFF_VALUE: rd_word = value;
			OFF_MIN: rd_word = min_val;
			OFF_MAX: rd_word = max_val;
			default: rd_hit = 1'b0;
		endcase
	end

	// every access answers in its first access cycle; read data is captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !rd_hit;
			if (psel && !penable && !pwrite)
				prdata <= rd_word;
		end
	end
endmodule // ccer_top

// >>> testbench/ccer_top_monitor.sv
// Purpose: concurrent checks on the ports of the error reporter
// Assumes: one clock domain, asynchronous active-low reset
// Notes: end-of-action checks look back two cycles, as the verdict may be registered twice
`timescale 1ns/1ps
module ccer_top_monitor #(
	parameter int unsigned TIMEOUT_CYC = 50
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// action engine
	input wire logic exec_start,
	input wire logic [3:0] exec_coil,
	input wire logic exec_done,
	input wire logic exec_fail,
	// status
	input wire logic [15:0] status_bits,
	input wire logic [31:0] error_code
);
	import ccer_pkg::*;
	int unsigned busy_cnt;
	// busy run length; a counter instead of a long repetition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= status_bits[BUSY_BIT] ? busy_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_end;
		$fell(status_bits[BUSY_BIT]);
	endsequence
	property p_flag;
		$changed(error_code) |-> status_bits[ERR_FLAG_BIT] == (error_code != CODE_SUCCESS);
	endproperty
	property p_spare;
		status_bits[13:0] == 14'h0000;
	endproperty
	property p_ready;
		s_setup |=> pready;
	endproperty
	property p_ready_src;
		pready |-> $past(psel && !penable);
	endproperty
	property p_err;
		pslverr |-> pready;
	endproperty
	property p_start;
		exec_start |-> status_bits[BUSY_BIT] ##1 !exec_start;
	endproperty
	property p_limit;
		busy_cnt <= TIMEOUT_CYC + 2;
	endproperty
	property p_tmo_code;
		s_end ##0 !$past(exec_done) ##0 !$past(exec_done, 2) |->
			error_code == CODE_TIMEOUT_CMD || error_code == CODE_TIMEOUT_ACT;
	endproperty
	property p_fail_code;
		s_end ##0 ($past(exec_done && exec_fail) || $past(exec_done && exec_fail, 2)) |->
			error_code == CODE_ACT_FAIL || error_code == CODE_ACK_SUPP;
	endproperty
	property p_coil;
		status_bits[BUSY_BIT] && $past(status_bits[BUSY_BIT]) |-> $stable(exec_coil);
	endproperty
	a_flag: assert property (p_flag)
		else $error("error flag disagrees with error code");
	a_spare: assert property (p_spare)
		else $error("spare status bits not zero");
	a_ready: assert property (p_ready)
		else $error("no ready after setup");
	a_ready_src: assert property (p_ready_src)
		else $error("ready without setup");
	a_err: assert property (p_err)
		else $error("slave error without ready");
	a_start: assert property (p_start)
		else $error("start not a busy one-cycle pulse");
	a_limit: assert property (p_limit)
		else $error("execution outlived its time limit");
	a_tmo_code: assert property (p_tmo_code)
		else $error("abandoned execution without timeout code");
	a_fail_code: assert property (p_fail_code)
		else $error("failed action without its code");
	a_coil: assert property (p_coil)
		else $error("coil index moved during execution");
endmodule // ccer_top_monitor

bind ccer_top ccer_top_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_ccer_top_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .exec_start(exec_start), .exec_coil(exec_coil),
	.exec_done(exec_done), .exec_fail(exec_fail), .status_bits(status_bits),
	.error_code(error_code));

// >>> testbench/ccer_engine_model.sv
// Purpose: behavioural action engine behind the error reporter
// Assumes: one start at a time; delay of at least one cycle
// Notes: the fail line toggles outside a done pulse so nothing leans on a stale value
`timescale 1ns/1ps
module ccer_engine_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// start from the block
	input wire logic exec_start,
	// behaviour chosen by the bench
	input wire logic [7:0] delay,
	input wire logic fail,
	input wire logic hang,
	// answer
	output logic exec_done,
	output logic exec_fail
);
	logic [7:0] left;
	// count down from each start; a hang keeps the action running forever
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left <= 8'h00;
			exec_done <= 1'b0;
			exec_fail <= 1'b1;
		end else begin
			exec_done <= 1'b0;
			exec_fail <= ~exec_fail;
			if (exec_start) begin
				left <= delay;
			end else if (left > 8'h01) begin
				left <= left - 8'h01;
			end else if (left == 8'h01 && !hang) begin
				left <= 8'h00;
				exec_done <= 1'b1;
				exec_fail <= fail;
			end
		end
	end
endmodule // ccer_engine_model

// >>> testbench/ccer_top_tb_top.sv
// Purpose: self-checking bench for the command channel error reporter
// Assumes: engine model answers each start unless hang is set; time limit shortened to 50 cycles
// Notes: each verdict is awaited by polling the error code under a bound
`timescale 1ns/1ps
module ccer_top_tb_top;
	import ccer_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, error_code, rd;
	logic pready, pslverr, exec_start, exec_done, exec_fail, err, exec_frame;
	logic [3:0] exec_coil;
	logic [15:0] status_bits, ack_bits;
	logic [7:0] delay = 8'h03;
	logic fail = 1'b0;
	logic hang = 1'b0;
	int mismatches = 0;
	int comparisons = 0;
	ccer_req_t r;
	logic [31:0] exp_tab [22] = '{CODE_EMPTY, CODE_NOT_RECOG, CODE_GRP_MISS, CODE_GRP_UNK,
		CODE_ITEM_MISS, CODE_ITEM_UNK, CODE_NOT_RD, CODE_EXTRA_ARGS, CODE_NOT_WR, CODE_NO_DATA,
		CODE_STR_LONG, CODE_BELOW_MIN, CODE_ABOVE_MAX, CODE_NOT_METH, CODE_ARG_CNT,
		CODE_NOT_READY, CODE_PC_NOT_READY, CODE_CMP_OFF, CODE_MASK_BAD, CODE_CMD_TRIG,
		CODE_FB_TRIG, CODE_BAD_ARG};
	always #10 pclk = ~pclk;
	ccer_top #(.TIMEOUT_CYC(50)) i_ccer_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .exec_start(exec_start), .exec_coil(exec_coil),
		.exec_frame(exec_frame), .exec_done(exec_done), .exec_fail(exec_fail),
		.status_bits(status_bits), .ack_bits(ack_bits), .error_code(error_code));
	ccer_engine_model i_ccer_engine_model (.pclk(pclk), .presetn(presetn),
		.exec_start(exec_start), .delay(delay), .fail(fail), .hang(hang),
		.exec_done(exec_done), .exec_fail(exec_fail));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one apb transfer; request held until ready is seen, then a quiet cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ok;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		ok = (pready === 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (!ok) begin
			mismatches++;
			wrap_up;
		end
	endtask
	// host side of the coil handshake: one write of the coil word; callers raise, hold and drop
	task automatic coil(input logic [15:0] c);
		apb(1'b1, OFF_COILS, {16'h0000, c});
	endtask
	task automatic wait_code(input logic [31:0] exp);
		int n;
		n = 0;
		while (error_code !== exp && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk(error_code, exp);
		if (error_code !== exp) begin
			wrap_up;
		end
	endtask
	// a good get request broken in one field per case, sent as a frame
	task automatic run_case(input int i);
		logic [31:0] cfg;
		logic [31:0] val;
		cfg = 32'h0000_030A;
		val = 32'h0000_0032;
		r = ccer_req_t'(22'h1F3E40);
		if (i >= 8 && i <= 12) begin
			r.op = OP_SET;
		end
		if (i == 13 || i == 14) begin
			r.op = OP_METHOD;
		end
		case (i)
			0: r.frame_empty = 1'b1;
			1: r.cmd_known = 1'b0;
			2: r.group_present = 1'b0;
			3: r.group_known = 1'b0;
			4: r.item_present = 1'b0;
			5: r.item_known = 1'b0;
			6: r.readable = 1'b0;
			7: r.extra_args = 1'b1;
			8: r.writeable = 1'b0;
			9: r.data_present = 1'b0;
			10: r.string_too_long = 1'b1;
			11: val = 32'hFFFF_FFFF;
			12: val = 32'h0000_0065;
			13: r.is_method = 1'b0;
			14: r.arg_count_ok = 1'b0;
			15: cfg = 32'h0000_020A;
			16: r.product_change = 1'b1;
			17: cfg = 32'h0000_010A;
			18: r.mask_valid = 1'b0;
			19: r.needs_cmd_trig = 1'b1;
			20: cfg = 32'h0000_0314;
			21: r.op = ccer_op_t'(2'h3);
			default: r.has_limits = 1'b0;
		endcase
		r.has_limits = (i == 11 || i == 12);
		r.needs_ready = (i == 15 || i == 16);
		r.uses_compare = (i == 17 || i == 18);
		r.needs_fb_trig = (i == 20);
		if (i == 16) begin
			cfg = 32'h0000_020A;
		end
		apb(1'b1, OFF_CONFIG, cfg);
		apb(1'b1, OFF_VALUE, val);
		apb(1'b1, OFF_REQ, 32'(r));
		apb(1'b1, OFF_GO, 32'h0000_0001);
		wait_code(exp_tab[i]);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFF_CONFIG, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({err, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, OFF_ERR_CODE, 32'h0000_1234);
		apb(1'b0, OFF_ERR_CODE, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b1, OFF_MAX, 32'h0000_0064);
		apb(1'b1, OFF_CONFIG, 32'h0000_030A);
		r = ccer_req_t'(22'h1F3E40);
		apb(1'b1, OFF_REQ, 32'(r));
		// failing action, then a clean one
		fail <= 1'b1;
		coil(16'h8000);
		wait_code(CODE_ACT_FAIL);
		chk({exec_frame, status_bits[15], ack_bits[15], exec_coil}, 32'h0000_003F);
		coil(16'h0000);
		fail <= 1'b0;
		coil(16'h8000);
		wait_code(CODE_SUCCESS);
		chk(32'(status_bits[15]), 32'h0000_0000);
		coil(16'h0000);
		r.cmd_known = 1'b0;
		apb(1'b1, OFF_REQ, 32'(r));
		coil(16'h8000);
		wait_code(CODE_UNKNOWN_ID);
		coil(16'h0000);
		for (int i = 0; i < 22; i++) begin
			run_case(i);
		end
		// handshake faults during one long action, then while idle
		apb(1'b1, OFF_CONFIG, 32'h0000_030A);
		r = ccer_req_t'(22'h1F3E40);
		apb(1'b1, OFF_REQ, 32'(r));
		// a clean frame submitted through the go register runs to completion
		apb(1'b1, OFF_GO, 32'h0000_0001);
		wait_code(CODE_SUCCESS);
		chk({status_bits[15], exec_frame}, 32'h0000_0001);
		delay <= 8'h28;
		coil(16'h8000);
		coil(16'h0000);
		wait_code(CODE_RELEASED);
		coil(16'h8000);
		wait_code(CODE_REASSERT);
		coil(16'h8001);
		wait_code(CODE_OTHER_PEND);
		apb(1'b1, OFF_GO, 32'h0000_0001);
		wait_code(CODE_BUSY);
		coil(16'h0001);
		wait_code(CODE_ACK_SUPP);
		chk(32'(ack_bits[15]), 32'h0000_0000);
		coil(16'h0000);
		delay <= 8'h03;
		coil(16'h0003);
		wait_code(CODE_MULTI);
		chk(32'(ack_bits[1:0]), 32'h0000_0003);
		coil(16'h0000);
		apb(1'b1, OFF_CONFIG, 32'h0000_0314);
		coil(16'h0001);
		wait_code(CODE_FB_TRIG);
		coil(16'h0000);
		apb(1'b1, OFF_CONFIG, 32'h0000_030A);
		// actions that never finish
		hang <= 1'b1;
		coil(16'h8000);
		wait_code(CODE_TIMEOUT_CMD);
		coil(16'h0000);
		coil(16'h0001);
		wait_code(CODE_TIMEOUT_ACT);
		coil(16'h0000);
		wrap_up;
	end
endmodule // ccer_top_tb_top
